// ---- rtl/pwm_gen_map.svh ----
// Register offsets, field positions and reset values of the PWM generator core.
// Included by the package, by the core module and by the bench; holds definitions only.
`ifndef PWM_GEN_MAP_SVH
`define PWM_GEN_MAP_SVH

// Byte offsets of the APB registers, one aligned word each.
`define OFS_TIMEBASE_CTRL 8'h00
`define OFS_IO_CONTROL 8'h04
`define OFS_PERIOD 8'h08
`define OFS_DUTY 8'h0C
`define OFS_PHASE 8'h10
`define OFS_DEAD_TIME 8'h14
`define OFS_TRIG_COMPARE 8'h18
`define OFS_TRIG_CONTROL 8'h1C
`define OFS_SPECIAL_EVENT 8'h20
`define OFS_IRQ_STATUS 8'h24
`define OFS_IRQ_MASK 8'h28
`define OFS_COUNTER 8'h2C
`define OFS_CHAN_CONTROL 8'h30

// Field positions.
`define TB_ENABLE_BIT 0
`define TB_CENTER_BIT 1
`define TB_IMM_PERIOD_BIT 10
`define IO_EXCHANGE_BIT 1
`define IO_MODE_HI 11
`define IO_MODE_LO 10
`define TRG_DIV_HI 15
`define TRG_DIV_LO 12
`define TRG_START_HI 5
`define TRG_START_LO 0
`define CH_IMM_UPDATE_BIT 0
`define EV_TRIGGER_BIT 0
`define EV_SPECIAL_BIT 1
`define EV_ROLLOVER_BIT 2
`define EV_WIDTH 3

// Reset values.
`define PERIOD_RST 16'h00FF
`define DEAD_TIME_RST 16'h0004
`define VALUE_RST 16'h0000

// Least trigger compare value that software should program.
`define TRIG_COMPARE_MIN 16'h0008

`endif

// ---- rtl/pwm_gen_pkg.sv ----
// Types shared by the PWM generator core and its dead-time stage.
// Assumes the map header sits beside it in rtl/.
`include "pwm_gen_map.svh"

package pwm_gen_pkg;

  // Output mode field encoding, in hardware order 00..11.
  typedef enum logic [1:0] {MODE_COMPLEMENTARY, MODE_REDUNDANT, MODE_PUSH_PULL, MODE_INDEPENDENT} out_mode_e;

  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_e;

  typedef struct packed {
    logic high;
    logic low;
  } pin_pair_s;

  typedef struct packed {
    logic enable;
    logic center;
    logic imm_period;
  } timebase_ctrl_s;

  typedef struct packed {
    out_mode_e mode;
    logic exchange;
  } io_ctrl_s;

  typedef struct packed {
    logic [3:0] divider;
    logic [5:0] start;
  } trig_ctrl_s;

  // Whole state of the core, registered by one process.
  typedef struct packed {
    timebase_ctrl_s tb;
    io_ctrl_s io;
    logic imm_update;
    logic [15:0] period_shadow;
    logic [15:0] period;
    logic [15:0] duty;
    logic [15:0] phase_shadow;
    logic phase_pending;
    logic [15:0] dead_time;
    logic [15:0] trig_cmp;
    logic [15:0] sevt_cmp;
    trig_ctrl_s trg;
    logic [`EV_WIDTH-1:0] status;
    logic [`EV_WIDTH-1:0] mask;
    logic [15:0] cnt;
    count_dir_e dir;
    logic steer;
    logic [5:0] start_wait;
    logic [3:0] div_cnt;
    logic trig_pulse;
    logic [31:0] rdata;
  } core_state_s;

endpackage : pwm_gen_pkg

// ---- rtl/pwm_dead_time.sv ----
// Dead-time stage for one pin pair: holds both pins off after any change of request.
// Assumes requests are synchronous to pclk and already routed to their final pins.
module pwm_dead_time
  import pwm_gen_pkg::*;
#(
  parameter int DT_W = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Requested pin levels and the gap length in cycles, less one.
  input pin_pair_s request,
  input wire logic [DT_W-1:0] dead_cycles,
  // Driven pin levels.
  output pin_pair_s pins
);

  typedef struct packed {
    pin_pair_s out;
    pin_pair_s target;
    logic [DT_W-1:0] cnt;
  } dt_state_s;

  dt_state_s s;
  dt_state_s next_s;

  // A counter wider than the register bus value cannot be loaded.
  if (DT_W < 1 || DT_W > 16) begin : g_check
    $error("pwm_dead_time: DT_W must be 1 to 16");
  end

  // Every change of the request opens a gap, so a pin swap in flight also gets one.
  always_comb begin
    next_s = s;
    if (request != s.target) begin
      next_s.target = request;
      next_s.cnt = dead_cycles;
      next_s.out = '0;
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
      next_s.out = '0;
    end else begin
      next_s.out = s.target;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pins = s.out;

endmodule : pwm_dead_time

// ---- rtl/pwm_generator_core.sv ----
// PWM generator core: one channel with its own time base, APB register file,
// output modes, dead time, pin exchange, primary trigger and special event.
// Assumes a single pclk domain, an APB master and presetn asynchronous active low.
//
// The placing of the registers and register access over APB were decided locally.
`include "pwm_gen_map.svh"

module pwm_generator_core
  import pwm_gen_pkg::*;
#(
  parameter int DEAD_W = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PWM pins and events.
  output logic pwm_high_output,
  output logic pwm_low_output,
  output logic trigger_output,
  output logic irq
);

  core_state_s s;
  core_state_s next_s;
  logic wr_access;
  logic rd_setup;
  logic addr_hit;
  logic rollover;
  logic midpoint;
  logic trig_match;
  logic sevt_match;
  logic raw_pwm;
  logic [`EV_WIDTH-1:0] events;
  logic [31:0] read_value;
  pin_pair_s mode_pins;
  pin_pair_s routed_pins;
  pin_pair_s driven_pins;

  // The dead-time counter is loaded from a 16-bit register field.
  if (DEAD_W < 1 || DEAD_W > 16) begin : g_check
    $error("pwm_generator_core: DEAD_W must be 1 to 16");
  end

  // Decode: writes take effect in the access phase, reads are sampled in setup.
  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  // Address decode and read multiplexer; unmapped words read as zero.
  always_comb begin
    addr_hit = 1'b1;
    read_value = 32'h0000_0000;
    unique case (paddr)
      `OFS_TIMEBASE_CTRL: begin
        read_value[`TB_ENABLE_BIT] = s.tb.enable;
        read_value[`TB_CENTER_BIT] = s.tb.center;
        read_value[`TB_IMM_PERIOD_BIT] = s.tb.imm_period;
      end
      `OFS_IO_CONTROL: begin
        read_value[`IO_MODE_HI:`IO_MODE_LO] = s.io.mode;
        read_value[`IO_EXCHANGE_BIT] = s.io.exchange;
      end
      `OFS_PERIOD: read_value[15:0] = s.period_shadow;
      `OFS_DUTY: read_value[15:0] = s.duty;
      `OFS_PHASE: read_value[15:0] = s.phase_shadow;
      `OFS_DEAD_TIME: read_value[15:0] = s.dead_time;
      `OFS_TRIG_COMPARE: read_value[15:0] = s.trig_cmp;
      `OFS_TRIG_CONTROL: begin
        read_value[`TRG_DIV_HI:`TRG_DIV_LO] = s.trg.divider;
        read_value[`TRG_START_HI:`TRG_START_LO] = s.trg.start;
      end
      `OFS_SPECIAL_EVENT: read_value[15:0] = s.sevt_cmp;
      `OFS_IRQ_STATUS: read_value[`EV_WIDTH-1:0] = s.status;
      `OFS_IRQ_MASK: read_value[`EV_WIDTH-1:0] = s.mask;
      `OFS_COUNTER: read_value[15:0] = s.cnt;
      `OFS_CHAN_CONTROL: read_value[`CH_IMM_UPDATE_BIT] = s.imm_update;
      default: addr_hit = 1'b0;
    endcase
  end

  // Compare events count only on the up slope so center mode fires once per cycle.
  assign trig_match = s.tb.enable & (s.dir == DIR_UP) & (s.cnt == s.trig_cmp);
  assign sevt_match = s.tb.enable & (s.dir == DIR_UP) & (s.cnt == s.sevt_cmp);

  // Next-state logic: time base, pending updates, trigger chain, then bus writes.
  always_comb begin
    next_s = s;
    rollover = 1'b0;
    midpoint = 1'b0;
    events = '0;
    next_s.trig_pulse = 1'b0;

    // Time base. A period write never creates a rollover of its own; only cnt >= period in edge mode, or cnt == 0 counting down in center mode, does.
    if (!s.tb.enable) begin
      next_s.cnt = `VALUE_RST;
      next_s.dir = DIR_UP;
    end else if (s.tb.center) begin
      if (s.dir == DIR_UP) begin
        if (s.cnt >= s.period) begin
          midpoint = 1'b1;
          next_s.dir = DIR_DOWN;
          next_s.cnt = (s.cnt == 16'h0000) ? 16'h0000 : s.cnt - 16'h0001;
        end else begin
          next_s.cnt = s.cnt + 16'h0001;
        end
      end else begin
        if (s.cnt == 16'h0000) begin
          rollover = 1'b1;
          next_s.dir = DIR_UP;
          next_s.cnt = 16'h0001;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
    end else begin
      if (s.cnt >= s.period) begin
        rollover = 1'b1;
        next_s.cnt = 16'h0000;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end

    // Cycle start: load the buffered period unless imm_period is set, and flip the push-pull steering exactly once.
    if (rollover) begin
      events[`EV_ROLLOVER_BIT] = 1'b1;
      next_s.steer = ~s.steer;
      if (!s.tb.imm_period) begin
        next_s.period = s.period_shadow;
      end
    end

    // Buffered phase lands at the midpoint in center mode, at rollover otherwise.
    if (!s.imm_update && s.phase_pending && (s.tb.center ? midpoint : rollover)) begin
      next_s.cnt = s.phase_shadow;
      next_s.phase_pending = 1'b0;
    end

    // Trigger chain: wait out the postscaler start cycles, then divide compare events.
    if (!s.tb.enable) begin
      next_s.start_wait = s.trg.start;
      next_s.div_cnt = 4'h0;
    end else begin
      if (rollover && s.start_wait != 6'h00) begin
        next_s.start_wait = s.start_wait - 6'h01;
      end
      if (trig_match && s.start_wait == 6'h00) begin
        if (s.div_cnt >= s.trg.divider) begin
          next_s.div_cnt = 4'h0;
          next_s.trig_pulse = 1'b1;
          events[`EV_TRIGGER_BIT] = 1'b1;
        end else begin
          next_s.div_cnt = s.div_cnt + 4'h1;
        end
      end
    end
    if (sevt_match) begin
      events[`EV_SPECIAL_BIT] = 1'b1;
    end

    // Register writes. Full-word writes only; a write with no strobe lane set is ignored.
    if (wr_access && addr_hit && pstrb != 4'h0) begin
      unique case (paddr)
        `OFS_TIMEBASE_CTRL: begin
          next_s.tb.enable = pwdata[`TB_ENABLE_BIT];
          next_s.tb.center = pwdata[`TB_CENTER_BIT];
          next_s.tb.imm_period = pwdata[`TB_IMM_PERIOD_BIT];
        end
        `OFS_IO_CONTROL: begin
          next_s.io.mode = out_mode_e'(pwdata[`IO_MODE_HI:`IO_MODE_LO]);
          next_s.io.exchange = pwdata[`IO_EXCHANGE_BIT];
        end
        `OFS_PERIOD: begin
          next_s.period_shadow = pwdata[15:0];
          if (s.tb.imm_period) begin
            next_s.period = pwdata[15:0];
          end
        end
        `OFS_DUTY: next_s.duty = pwdata[15:0];
        `OFS_PHASE: begin
          next_s.phase_shadow = pwdata[15:0];
          if (s.imm_update) begin
            next_s.cnt = pwdata[15:0];
            next_s.phase_pending = 1'b0;
          end else begin
            next_s.phase_pending = 1'b1;
          end
        end
        `OFS_DEAD_TIME: next_s.dead_time = pwdata[15:0];
        `OFS_TRIG_COMPARE: next_s.trig_cmp = pwdata[15:0];
        `OFS_TRIG_CONTROL: begin
          next_s.trg.divider = pwdata[`TRG_DIV_HI:`TRG_DIV_LO];
          next_s.trg.start = pwdata[`TRG_START_HI:`TRG_START_LO];
        end
        `OFS_SPECIAL_EVENT: next_s.sevt_cmp = pwdata[15:0];
        `OFS_IRQ_STATUS: next_s.status = s.status & ~pwdata[`EV_WIDTH-1:0];
        `OFS_IRQ_MASK: next_s.mask = pwdata[`EV_WIDTH-1:0];
        `OFS_CHAN_CONTROL: next_s.imm_update = pwdata[`CH_IMM_UPDATE_BIT];
        default: next_s.status = next_s.status;
      endcase
    end

    // New events are merged after the clear so an event in the clearing cycle survives.
    next_s.status = next_s.status | events;

    // Read data is captured in the setup cycle and stands through the access phase.
    if (rd_setup) begin
      next_s.rdata = read_value;
    end
  end

  // State register with documented reset values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.io.mode <= MODE_COMPLEMENTARY;
      s.period_shadow <= `PERIOD_RST;
      s.period <= `PERIOD_RST;
      s.dead_time <= `DEAD_TIME_RST;
    end else begin
      s <= next_s;
    end
  end

  // Raw duty compare; in center mode the pulse is symmetric about the cycle start.
  assign raw_pwm = s.tb.enable & (s.cnt < s.duty);

  // Mode shaping. Push-pull swaps pins at each rollover, so edge-mode pulses alternate and center-mode pulses split between pins.
  always_comb begin
    mode_pins = '0;
    unique case (s.io.mode)
      MODE_COMPLEMENTARY: begin
        mode_pins.high = raw_pwm;
        mode_pins.low = s.tb.enable & ~raw_pwm;
      end
      MODE_PUSH_PULL: begin
        mode_pins.high = raw_pwm & ~s.steer;
        mode_pins.low = raw_pwm & s.steer;
      end
      MODE_REDUNDANT, MODE_INDEPENDENT: begin
        mode_pins.high = raw_pwm;
        mode_pins.low = raw_pwm;
      end
    endcase
  end

  // Exchange sits before the dead-time stage so that changing it opens a gap rather than
  // flipping both pins in one edge, which would short a half bridge.
  always_comb begin
    routed_pins = mode_pins;
    if (s.io.exchange) begin
      routed_pins.high = mode_pins.low;
      routed_pins.low = mode_pins.high;
    end
  end

  pwm_dead_time #(
    .DT_W(DEAD_W)
  ) u_dead_time (
    .pclk(pclk),
    .presetn(presetn),
    .request(routed_pins),
    .dead_cycles(s.dead_time[DEAD_W-1:0]),
    .pins(driven_pins)
  );

  // Outputs; APB answers with no wait states.
  assign pwm_high_output = driven_pins.high;
  assign pwm_low_output = driven_pins.low;
  assign trigger_output = s.trig_pulse;
  assign irq = |(s.status & s.mask);
  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

endmodule : pwm_generator_core

// ---- dv/pwm_switch_model.sv ----
// Model of the external power switch pair driven by the two PWM pins.
// Assumes gate levels are sampled on pclk and both switches start open.
module pwm_switch_model (
  // Clock.
  input wire logic pclk,
  // Gate drives from the core.
  input wire logic gate_high,
  input wire logic gate_low,
  // Counts of shoot-through cycles and of repeated pulses on one switch.
  output int shoot,
  output int reps
);
  logic ph;
  logic pl;
  logic last_pin;
  logic seen;

  // Start with both switches open and no pulse history.
  initial begin
    shoot = 0;
    reps = 0;
    ph = 1'b0;
    pl = 1'b0;
    last_pin = 1'b0;
    seen = 1'b0;
  end

  // Both switches closed at once would short the supply; a switch turning on twice in a row heats it.
  always @(posedge pclk) begin
    if (gate_high === 1'b1 && gate_low === 1'b1) shoot++;
    if ((gate_high === 1'b1 && !ph) || (gate_low === 1'b1 && !pl)) begin
      if (seen && last_pin == gate_high) reps++;
      last_pin = gate_high;
      seen = 1'b1;
    end
    ph = (gate_high === 1'b1);
    pl = (gate_low === 1'b1);
  end
endmodule : pwm_switch_model

// ---- dv/pwm_generator_core_chk.sv ----
// Checker of the PWM core port behaviour: APB answers, pin gaps, trigger pulse.
// Assumes a single pclk domain and presetn asynchronous active low.
module pwm_generator_core_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB signals.
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins.
  input wire logic pwm_high_output,
  input wire logic pwm_low_output,
  input wire logic trigger_output
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Steps of an APB access and of a trigger pulse.
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_trig_done;
    trigger_output ##1 !trigger_output;
  endsequence

  // A switch only turns on after the opposite one was already off.
  a_pins_exclusive: assert property (!(pwm_high_output && pwm_low_output)) else $error("pins both on");
  a_high_after_gap: assert property ($rose(pwm_high_output) |-> !$past(pwm_low_output)) else $error("no gap");
  a_low_after_gap: assert property ($rose(pwm_low_output) |-> !$past(pwm_high_output)) else $error("no gap");
  a_trig_one_cycle: assert property (trigger_output |-> s_trig_done) else $error("trigger too long");

  // The slave never waits and flags only unmapped accesses.
  a_ready_const: assert property (pready) else $error("pready low");
  a_err_in_access: assert property (pslverr |-> s_acc) else $error("pslverr outside access");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h30 |-> pslverr && prdata == 32'h0) else
    $error("unmapped not refused");
  a_rdata_hold: assert property (s_acc |=> $stable(prdata)) else $error("read data moved");
endmodule : pwm_generator_core_chk

bind pwm_generator_core pwm_generator_core_chk pwm_generator_core_chk_inst (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .pwm_high_output(pwm_high_output),
  .pwm_low_output(pwm_low_output),
  .trigger_output(trigger_output)
);

// ---- dv/tb_pwm_generator_core.sv ----
// Self-checking bench of the PWM core through its APB port.
// Assumes the map header is on the include path and the checker is bound.
`include "pwm_gen_map.svh"
module tb_pwm_generator_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pslverr, pready, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] pstrb;
  logic pwm_high_output, pwm_low_output, trigger_output, irq;
  int err_total, checked, hi, lo, n, t0, t2, shoot, reps;

  pwm_generator_core pwm_generator_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_high_output(pwm_high_output), .pwm_low_output(pwm_low_output),
    .trigger_output(trigger_output), .irq(irq));
  pwm_switch_model pwm_switch_model_inst (.pclk(pclk), .gate_high(pwm_high_output), .gate_low(pwm_low_output),
    .shoot(shoot), .reps(reps));

  // Clock of 4 ns period.
  always #2 pclk = ~pclk;

  // One APB transfer; read data and error are taken at the completing edge.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("BAD %0t: got %h expected %h", $time, s, x);
    end
  endtask : chk

  // Counts on-cycles of each pin over a window after settling.
  task automatic on(input int c);
    repeat (40) @(posedge pclk);
    hi = 0;
    lo = 0;
    repeat (c) begin
      @(posedge pclk);
      hi += int'(pwm_high_output === 1'b1);
      lo += int'(pwm_low_output === 1'b1);
    end
  endtask : on

  // Cycles between a trigger pulse and the previous reference point.
  task automatic wtrig(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (trigger_output !== 1'b1);
  endtask : wtrig

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    acc(0, `OFS_PERIOD, 0); chk(d, 32'h0000_00FF);
    acc(0, `OFS_DEAD_TIME, 0); chk(d, 32'h0000_0004);
    acc(0, 8'h40, 0); chk(d, 32'h0); chk(e, 1'b1);
    // Complementary, duty 5 of 20, dead time 2 gives 3 off cycles per change.
    // A buffered period only loads at rollover, so the idle time base takes it through the immediate bit.
    acc(1, `OFS_TIMEBASE_CTRL, 32'h400);
    acc(1, `OFS_PERIOD, 32'h13); acc(1, `OFS_DUTY, 32'h5); acc(1, `OFS_DEAD_TIME, 32'h2);
    acc(1, `OFS_TIMEBASE_CTRL, 32'h1);
    on(40); chk(hi, 4); chk(lo, 24);
    acc(1, `OFS_IO_CONTROL, 32'h2); on(40); chk(hi, 24); chk(lo, 4);
    acc(1, `OFS_IO_CONTROL, 32'h0); on(40); chk(hi, 4); chk(shoot, 0);
    // Push-pull alternates one pulse per period between the pins.
    acc(1, `OFS_IO_CONTROL, 32'h800); on(40); chk(hi, 2); chk(lo, 2);
    n = reps;
    acc(1, `OFS_TIMEBASE_CTRL, 32'h401);
    for (int i = 0; i < 12; i++) acc(1, `OFS_PERIOD, 32'h11 + i[1:0]);
    on(40); chk(reps - n, 0);
    // Phase applies at once with immediate update, later without.
    acc(1, `OFS_IO_CONTROL, 0); acc(1, `OFS_PERIOD, 32'hFF); acc(1, `OFS_CHAN_CONTROL, 32'h1);
    acc(1, `OFS_PHASE, 32'h80); acc(0, `OFS_COUNTER, 0); chk(d >= 32'h80 && d <= 32'h84, 1);
    acc(1, `OFS_PHASE, 0); acc(1, `OFS_TIMEBASE_CTRL, 32'h3); acc(1, `OFS_CHAN_CONTROL, 0);
    acc(1, `OFS_PHASE, 32'hF0); acc(0, `OFS_COUNTER, 0); chk(d < 32'h40, 1);
    // Past the midpoint the counter runs down from the buffered phase, not from the period.
    repeat (250) @(posedge pclk);
    acc(0, `OFS_COUNTER, 0); chk(d > 32'hE0 && d < 32'hF0, 1);
    // Trigger with compare 3, every period, then divided, then delayed start.
    acc(1, `OFS_TIMEBASE_CTRL, 32'h400); acc(1, `OFS_PERIOD, 32'h13); acc(1, `OFS_CHAN_CONTROL, 32'h1);
    acc(1, `OFS_PHASE, 0); acc(1, `OFS_TRIG_COMPARE, 32'h3); acc(1, `OFS_IRQ_MASK, 32'h1);
    acc(1, `OFS_TIMEBASE_CTRL, 32'h1); wtrig(t0); chk(t0, 5);
    wtrig(n); chk(n, 20);
    chk(irq, 1);
    acc(1, `OFS_TRIG_CONTROL, 32'h1000); wtrig(n); wtrig(n); chk(n, 40);
    acc(1, `OFS_TIMEBASE_CTRL, 0); acc(1, `OFS_TRIG_CONTROL, 32'h2); acc(1, `OFS_PHASE, 0);
    acc(1, `OFS_TIMEBASE_CTRL, 32'h1); wtrig(t2); chk(t2 - t0, 40);
    acc(1, `OFS_TRIG_COMPARE, `TRIG_COMPARE_MIN);
    acc(1, `OFS_IRQ_MASK, 0); #1 chk(irq, 0);
    acc(1, `OFS_TIMEBASE_CTRL, 0); acc(1, `OFS_IRQ_STATUS, 32'h7); acc(0, `OFS_IRQ_STATUS, 0); chk(d, 0);
    // Special event sets its own status bit and interrupt.
    acc(1, `OFS_SPECIAL_EVENT, 32'h7); acc(1, `OFS_IRQ_MASK, 32'h2); acc(1, `OFS_TIMEBASE_CTRL, 32'h1);
    repeat (25) @(posedge pclk);
    #1 chk(irq, 1);
    acc(0, `OFS_IRQ_STATUS, 0); chk(d[1], 1);
    give_verdict();
  end

  // Watchdog well beyond the thousand or so cycles the sequence needs.
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule : tb_pwm_generator_core
